// File: src/ssc_pkg.sv
/*
  shared types and constants of the smart card interface control block.
  assumes a single 250 MHz system clock; the lockout and step times are derived from it, the card clock from osc_input.
*/
package ssc_pkg;
  localparam int CLK_FREQ_MHZ = 250;
  // power-on / supply recovery lockout
  localparam int POR_HOLD_MS = 10;
  localparam int POR_HOLD_CYCLES = POR_HOLD_MS * 1000 * CLK_FREQ_MHZ;
  // spacing of sequencer steps
  localparam int SEQ_STEP_US = 1;
  localparam int SEQ_STEP_CYCLES = SEQ_STEP_US * CLK_FREQ_MHZ;
  // card clock periods before reset may rise
  localparam logic [15:0] RST_HOLD_CARD_CLKS = 16'hA410;
  // card clock period counted in oscillator half periods
  localparam logic [4:0] HALF_PER_DIV8 = 5'h10;
  localparam logic [4:0] HALF_PER_DIV4 = 5'h08;
  localparam logic [4:0] HALF_PER_DIV2 = 5'h04;
  localparam logic [4:0] HALF_PER_DIV1 = 5'h02;
  localparam logic [1:0] RATIO_DIV8 = 2'h0;
  localparam logic [1:0] RATIO_DIV4 = 2'h1;
  localparam logic [1:0] RATIO_DIV1 = 2'h2;
  localparam logic [1:0] RATIO_DIV2 = 2'h3;

  typedef struct packed {
    logic activation_command_n;
    logic card_reset_request;
    logic card_voltage_select;
    logic clock_ratio_sel_a;
    logic clock_ratio_sel_b;
    logic card_clock_halt;
    logic halt_clock_level;
  } ssc_host_t;

  typedef struct packed {
    logic card_present;
    logic vdd_fault;
    logic vpc_fault;
    logic vcc_fault;
    logic vpc_below_vcc;
    logic over_temp;
    logic over_current;
  } ssc_sense_t;

  typedef struct packed {
    logic vcc_enable;
    logic vcc_high_sel;
    logic io_reception;
    logic card_clk;
    logic card_rst;
  } ssc_card_t;

  typedef enum logic [2:0] {
    S_IDLE, S_RAMP, S_IO_ON, S_CLK_ON, S_ACTIVE, S_D_RST, S_D_CLK, S_D_IO
  } ssc_state_t;
endpackage

// File: src/ssc_clkgen.sv
/*
  card clock generator: divides the oscillator input and stops the clock
  at a chosen level. assumes osc_input is sampled on clk and runs slower
  than half the clk rate.
*/
`timescale 1ns/10ps
module ssc_clkgen
  import ssc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       osc_input,
  input  wire logic       run,
  input  wire logic       halt,
  input  wire logic       level,
  input  wire logic [1:0] ratio,
  output logic            card_clk,
  output logic            card_rise
);
  logic       osc_q;
  logic       go_q;
  logic       clk_q;
  logic       rise_q;
  logic [4:0] ph_q;
  logic [4:0] per_q;
  logic [4:0] per_sel;
  logic       osc_edge;
  logic       boundary;
  logic       go_d;
  logic [4:0] ph_d;
  logic [4:0] per_d;

  always_comb begin
    case (ratio)
      RATIO_DIV8: per_sel = HALF_PER_DIV8;
      RATIO_DIV4: per_sel = HALF_PER_DIV4;
      RATIO_DIV1: per_sel = HALF_PER_DIV1;
      RATIO_DIV2: per_sel = HALF_PER_DIV2;
      default:    per_sel = HALF_PER_DIV8;
    endcase
  end

  assign osc_edge = osc_input ^ osc_q;
  assign boundary = !go_q || (ph_q == per_q - 5'h01);

  // new ratio and halt only taken at the end of a whole period
  always_comb begin
    go_d  = go_q;
    ph_d  = ph_q;
    per_d = per_q;
    if (osc_edge && boundary) begin
      go_d  = run && !halt;
      per_d = per_sel;
      ph_d  = 5'h00;
    end else if (osc_edge) begin
      ph_d = ph_q + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_q  <= 1'b0;
      go_q   <= 1'b0;
      ph_q   <= 5'h00;
      per_q  <= HALF_PER_DIV8;
      clk_q  <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      osc_q  <= osc_input;
      go_q   <= go_d;
      ph_q   <= ph_d;
      per_q  <= per_d;
      rise_q <= osc_edge && go_d && (ph_d == 5'h00);
      if (go_d) begin
        clk_q <= ph_d < (per_d >> 1);
      end else begin
        clk_q <= run && level;
      end
    end
  end

  assign card_clk  = clk_q;
  assign card_rise = rise_q;

  a_halt_level: assert property (@(posedge clk) disable iff (!rst_n)
    (!go_q && !go_d && run) |=> (card_clk == $past(level)))
    else $error("halted card clock not at requested level");
  a_stop_low: assert property (@(posedge clk) disable iff (!rst_n)
    (!go_q && !run) |=> !card_clk)
    else $error("stopped card clock not low");
endmodule

// File: src/ssc_ctrl.sv
/*
  smart card interface control: activation/deactivation sequencer,
  card reset gating, clock control and presence/fault interrupt pin.
  assumes all inputs synchronous to clk; supervisors and detectors are
  outside and report as levels.
*/
`timescale 1ns/10ps
module ssc_ctrl
  import ssc_pkg::*;
#(
  parameter int          POR_CYCLES  = POR_HOLD_CYCLES,
  parameter int          STEP_CYCLES = SEQ_STEP_CYCLES,
  parameter logic [15:0] RST_CLKS    = RST_HOLD_CARD_CLKS
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire ssc_host_t  host,
  input  wire ssc_sense_t sense,
  input  wire logic       osc_input,
  input  wire logic       fault_irq_n_i,
  output logic            fault_irq_n_o,
  output logic            fault_irq_n_oe,
  output ssc_card_t       card
);
  localparam int PW = $clog2(POR_CYCLES + 1);
  localparam int SW = $clog2(STEP_CYCLES + 1);

  ssc_state_t    state_q;
  ssc_state_t    state_d;
  logic [PW-1:0] inh_q;
  logic [SW-1:0] step_q;
  logic          cmd_q;
  logic          fault_q;
  logic          irq_q;
  logic          vsel_q;
  logic          vcc_q;
  logic          io_q;
  logic          run_q;
  logic          gate_q;
  logic          rst_q;
  logic [15:0]   ccnt_q;
  logic          card_clk;
  logic          card_rise;
  logic          session;
  logic          fault_any;
  logic          start_ok;
  logic          step_done;
  logic          in_act;

  assign session   = !host.activation_command_n;
  assign fault_any = !sense.card_present || sense.vdd_fault || sense.vpc_fault
                     || sense.vcc_fault || sense.vpc_below_vcc || sense.over_temp
                     || sense.over_current;
  assign start_ok  = cmd_q && session && sense.card_present && !sense.over_temp
                     && !sense.vdd_fault && (inh_q == '0);
  assign step_done = (step_q == '0);
  assign in_act    = (state_q == S_RAMP) || (state_q == S_IO_ON)
                     || (state_q == S_CLK_ON) || (state_q == S_ACTIVE);

  // lockout after reset or digital supply recovery
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      inh_q <= PW'(POR_CYCLES);
    end else if (sense.vdd_fault) begin
      inh_q <= PW'(POR_CYCLES);
    end else if (inh_q != '0) begin
      inh_q <= inh_q - PW'(1);
    end
  end

  // sticky session fault, the end of session clears it even with a fault present
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fault_q <= 1'b0;
      cmd_q   <= 1'b1;
    end else begin
      cmd_q <= host.activation_command_n;
      if (session && fault_any && state_q != S_IDLE) begin
        fault_q <= 1'b1;
      end else if (!session) begin
        fault_q <= 1'b0;
      end
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE:   if (start_ok) state_d = S_RAMP;
      S_RAMP:   if (step_done) state_d = S_IO_ON;
      S_IO_ON:  if (step_done) state_d = S_CLK_ON;
      S_CLK_ON: if (step_done) state_d = S_ACTIVE;
      S_ACTIVE: state_d = S_ACTIVE;
      S_D_RST:  if (step_done) state_d = S_D_CLK;
      S_D_CLK:  if (step_done) state_d = S_D_IO;
      S_D_IO:   if (step_done) state_d = S_IDLE;
      default:  state_d = S_IDLE;
    endcase
    if (in_act && (!session || fault_any || fault_q)) begin
      state_d = S_D_RST;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      step_q  <= '0;
    end else begin
      state_q <= state_d;
      if (state_d != state_q) begin
        step_q <= SW'(STEP_CYCLES - 1);
      end else if (!step_done) begin
        step_q <= step_q - SW'(1);
      end
    end
  end

  // card side controls follow the next sequencer state; voltage select is taken from the host while idle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vsel_q <= 1'b0;
      vcc_q  <= 1'b0;
      io_q   <= 1'b0;
      run_q  <= 1'b0;
    end else begin
      if (state_q == S_IDLE) begin
        vsel_q <= host.card_voltage_select;
      end
      vcc_q <= (state_d != S_IDLE);
      io_q  <= (state_d == S_IO_ON) || (state_d == S_CLK_ON) || (state_d == S_ACTIVE)
               || (state_d == S_D_RST) || (state_d == S_D_CLK);
      run_q <= (state_d == S_CLK_ON) || (state_d == S_ACTIVE) || (state_d == S_D_RST);
    end
  end

  // card clocks since clock start, then reset path opened
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ccnt_q <= 16'h0000;
      gate_q <= 1'b0;
      rst_q  <= 1'b0;
    end else begin
      if (!run_q || !in_act) begin
        ccnt_q <= 16'h0000;
      end else if (card_rise && ccnt_q != RST_CLKS) begin
        ccnt_q <= ccnt_q + 16'h0001;
      end
      gate_q <= (state_d == S_ACTIVE) && (ccnt_q == RST_CLKS);
      rst_q  <= gate_q && (state_d == S_ACTIVE) && host.card_reset_request;
    end
  end

  // presence outside a session, fault inside one
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else if (session) begin
      irq_q <= fault_q || (in_act && fault_any);
    end else begin
      irq_q <= !sense.card_present;
    end
  end

  ssc_clkgen ssc_clkgen_i (
    .clk       (clk),
    .rst_n     (rst_n),
    .osc_input (osc_input),
    .run       (run_q),
    .halt      (host.card_clock_halt),
    .level     (host.halt_clock_level),
    .ratio     ({host.clock_ratio_sel_a, host.clock_ratio_sel_b}),
    .card_clk  (card_clk),
    .card_rise (card_rise)
  );

  assign fault_irq_n_o     = 1'b0;
  assign fault_irq_n_oe    = irq_q;
  assign card.vcc_enable   = vcc_q;
  assign card.vcc_high_sel = vsel_q;
  assign card.io_reception = io_q;
  assign card.card_clk     = card_clk;
  assign card.card_rst     = rst_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_start_seq: assert property (start_ok && state_q == S_IDLE |=> state_q == S_RAMP)
    else $error("activation request not started");
  a_rst_gate: assert property (card.card_rst |-> $past(gate_q) && $past(host.card_reset_request))
    else $error("card reset without enabled path");
  a_vsel_hold: assert property (state_q == S_IDLE |=> vsel_q == $past(host.card_voltage_select))
    else $error("voltage select not captured");
  a_idle_irq: assert property (!session |=> (irq_q == !$past(sense.card_present)))
    else $error("interrupt does not show presence");
  a_fault_irq: assert property (session && in_act && fault_any |=> irq_q)
    else $error("fault not reported in session");
  a_supply_deact: assert property (in_act && (sense.vpc_fault || sense.vpc_below_vcc || sense.vdd_fault)
    |=> state_q == S_D_RST)
    else $error("supply fault did not deactivate");
  a_temp_deact: assert property (session && in_act && sense.over_temp
    |=> state_q == S_D_RST && fault_irq_n_oe)
    else $error("over-temperature not handled");
  a_vcc_seq: assert property ($rose(card.vcc_enable) |-> $past(state_q) == S_IDLE && state_q == S_RAMP)
    else $error("card supply switched outside sequencer");
  a_no_card: assert property (state_q == S_IDLE && !sense.card_present |=> state_q == S_IDLE)
    else $error("activation without card");
  a_rst_delay: assert property ($rose(gate_q) |-> $past(ccnt_q) == RST_CLKS)
    else $error("reset path opened too early");
  a_lockout: assert property (inh_q != '0 && state_q == S_IDLE |=> state_q == S_IDLE)
    else $error("activation during lockout");
endmodule

// File: sim/ssc_host_model.sv
/*
  host side model: drives the command levels and the oscillator input.
  assumes the bench calls drive() to change the host levels.
*/
`timescale 1ns/10ps
module ssc_host_model
  import ssc_pkg::*;
(
  input  wire logic clk,
  output ssc_host_t host,
  output logic      osc_input
);
  logic [1:0] div_q;

  initial begin
    host = '{activation_command_n: 1'b1, default: 1'b0};
    osc_input = 1'b0;
    div_q = 2'h0;
  end

  // oscillator toggles every 2nd clk, off the sampling edge
  always @(negedge clk) begin
    div_q <= div_q + 2'h1;
    if (div_q[0])
      osc_input <= ~osc_input;
  end

  // host levels change just after a falling edge
  task automatic drive(input ssc_host_t v);
    @(negedge clk);
    host = v;
  endtask
endmodule

// File: sim/tb_ssc_ctrl.sv
/*
  bench for ssc_ctrl: lockout, activation, divide, halt and faults.
  assumes short lockout and step parameters and the host model.
*/
`timescale 1ns/10ps
module tb_ssc_ctrl
  import ssc_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  ssc_host_t  h;
  ssc_host_t  host;
  ssc_sense_t s;
  ssc_card_t  card;
  logic       osc_input;
  logic       irq_o;
  logic       irq_oe;
  int         miscompares = 0;
  int         n_tests = 0;
  wire logic  irq_pin = irq_oe ? irq_o : 1'b1;
  int         per_exp[4] = '{32, 16, 4, 8};

  initial forever #2 clk = ~clk;

  ssc_ctrl #(.POR_CYCLES(20), .STEP_CYCLES(4), .RST_CLKS(16'h0080)) ssc_ctrl_i (
    .clk(clk), .rst_n(rst_n), .host(host), .sense(s), .osc_input(osc_input),
    .fault_irq_n_i(irq_pin), .fault_irq_n_o(irq_o), .fault_irq_n_oe(irq_oe), .card(card));
  ssc_host_model ssc_host_model_i (.clk(clk), .host(host), .osc_input(osc_input));

  task automatic give_verdict;
    if (miscompares == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic sense(input ssc_sense_t v);
    @(negedge clk);
    s = v;
  endtask

  task automatic cmd(input logic v, input int n);
    h.activation_command_n = v;
    ssc_host_model_i.drive(h);
    cyc(n);
  endtask

  task automatic till(input logic v, inout int n);
    do begin
      cyc(1);
      n++;
    end while (card.card_clk !== v && n < 400);
  endtask

  task automatic period(output int p);
    int n;
    n = 0;
    till(1'b0, n);
    till(1'b1, n);
    p = 0;
    till(1'b0, p);
    till(1'b1, p);
  endtask

  task automatic t_reset;
    cyc(2);
    chk("card_idle", 8'h00, 8'(card));
    chk("oe_present", 8'h00, 8'(irq_oe));
    sense('{card_present: 1'b1, over_temp: 1'b1, default: 1'b0});
    cyc(2);
    chk("oe_idle_fault", 8'h00, 8'(irq_oe));
    sense('{card_present: 1'b0, default: 1'b0});
    cyc(2);
    chk("oe_no_card", 8'h01, 8'(irq_oe));
    sense('{card_present: 1'b1, default: 1'b0});
    cmd(1'b0, 8);
    chk("vcc_lockout", 8'h00, 8'(card.vcc_enable));
    cmd(1'b1, 30);
  endtask

  task automatic t_refuse;
    ssc_sense_t v[3] = '{7'h00, 7'h42, 7'h60};
    foreach (v[i]) begin
      sense(v[i]);
      cmd(1'b0, 10);
      chk("vcc_refused", 8'h00, 8'(card.vcc_enable));
      sense('{card_present: 1'b1, default: 1'b0});
      cmd(1'b1, 40);
    end
  endtask

  task automatic t_act(input logic sel);
    int p;
    int bad;
    h.card_voltage_select = sel;
    h.clock_ratio_sel_a = 1'b1;
    h.clock_ratio_sel_b = 1'b0;
    h.card_reset_request = 1'b1;
    cmd(1'b0, 2);
    chk("vcc_on", 8'h01, 8'(card.vcc_enable));
    chk("vcc_sel", 8'(sel), 8'(card.vcc_high_sel));
    chk("io_early", 8'h00, 8'(card.io_reception));
    cyc(6);
    chk("io_on", 8'h01, 8'(card.io_reception));
    period(p);
    chk("per_div1", 8'd4, 8'(p));
    bad = 0;
    repeat (300) begin
      cyc(1);
      bad += int'(card.card_rst !== 1'b0);
    end
    chk("rst_held", 8'h00, 8'(bad));
    cyc(300);
    chk("rst_open", 8'h01, 8'(card.card_rst));
    h.card_reset_request = 1'b0;
    ssc_host_model_i.drive(h);
    cyc(2);
    chk("rst_follow", 8'h00, 8'(card.card_rst));
    h.card_reset_request = 1'b1;
    cmd(1'b1, 80);
    chk("card_off", 8'({4'h0, sel, 3'h0}), 8'(card));
  endtask

  task automatic t_ratio;
    int p;
    cmd(1'b0, 20);
    for (int c = 0; c < 4; c++) begin
      {h.clock_ratio_sel_a, h.clock_ratio_sel_b} = 2'(c);
      ssc_host_model_i.drive(h);
      period(p);
      period(p);
      chk("per_ratio", 8'(per_exp[c]), 8'(p));
    end
    cmd(1'b1, 80);
  endtask

  task automatic t_halt;
    int p;
    int bad;
    {h.clock_ratio_sel_a, h.clock_ratio_sel_b} = 2'h3;
    cmd(1'b0, 20);
    for (int l = 0; l < 2; l++) begin
      h.card_clock_halt = 1'b1;
      h.halt_clock_level = 1'(l);
      ssc_host_model_i.drive(h);
      cyc(20);
      bad = 0;
      repeat (40) begin
        cyc(1);
        bad += int'(card.card_clk !== 1'(l));
      end
      chk("halt_level", 8'h00, 8'(bad));
      h.card_clock_halt = 1'b0;
      ssc_host_model_i.drive(h);
      period(p);
      period(p);
      chk("per_resume", 8'd8, 8'(p));
    end
    cmd(1'b1, 80);
  endtask

  task automatic t_fault;
    for (int i = 0; i < 7; i++) begin
      cmd(1'b0, 1100);
      chk("rst_before", 8'h01, 8'(card.card_rst));
      sense(i == 6 ? 7'h00 : 7'h40 | 7'(1 << i));
      cyc(2);
      chk("oe_fault", 8'h01, 8'(irq_oe));
      chk("rst_fault", 8'h00, 8'(card.card_rst));
      cyc(80);
      chk("vcc_fault", 8'h00, 8'(card.vcc_enable));
      chk("clk_fault", 8'h00, 8'(card.card_clk));
      sense('{card_present: 1'(i != 6), default: 1'b0});
      cmd(1'b1, 40);
      chk("oe_after", 8'(i == 6), 8'(irq_oe));
      sense('{card_present: 1'b1, default: 1'b0});
    end
  endtask

  initial begin
    h = '{activation_command_n: 1'b1, default: 1'b0};
    s = '{card_present: 1'b1, default: 1'b0};
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_reset;
    t_refuse;
    t_act(1'b1);
    t_act(1'b0);
    t_ratio;
    t_halt;
    t_fault;
    give_verdict;
  end

  // watchdog, well past the expected run time
  initial begin
    #120000;
    miscompares++;
    give_verdict;
  end
endmodule
